// ===== include/bitu_pkg.sv
// Purpose: shared constants and types of the branch and if-then unit
// Assumes: 32-bit core, single clock, decoder supplies operands
// Notes: condition codes use the usual 4-bit form, inverse flips bit 0
// Notes on behaviour
// - calls write next address to link register
// - register target with bit0 clear faults
// - register target has bit0 forced to zero
// - conditional jump outside block reaches one megabyte
// - block jump and direct forms reach sixteen megabytes
// - zero tests branch without touching flags
// - prefix makes one to four slots conditional
// - then keeps condition, else inverts it except on the always condition
// - debug halt in block always executes
// - exceptions save and restore block state
// - table entry doubled, forward from next instruction
// - half table index doubled, pc base follows
package bitu_pkg;
    localparam int XLEN = 32;
    localparam int NEAR_W = 21;
    localparam int FAR_W = 25;
    localparam int TZ_MIN_BYTES = 4;
    localparam int TZ_MAX_BYTES = 130;
    localparam logic [3:0] LINK_REG_IDX = 4'he;
    localparam logic [3:0] COND_ALWAYS = 4'he;
    localparam logic [3:0] COND_INV_MASK = 4'h1;
    localparam logic [2:0] IT_MAX_SLOTS = 3'h4;
    localparam int TGT_MODE_BIT = 0;
    localparam int TBL_SHIFT = 1;
    localparam logic [XLEN-1:0] NARROW_BYTES = 32'h2;
    localparam logic [XLEN-1:0] WIDE_BYTES = 32'h4;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_JUMP_DIRECT = 4'h1,
        OP_COND_JUMP = 4'h2,
        OP_CALL_DIRECT = 4'h3,
        OP_JUMP_REG = 4'h4,
        OP_CALL_REG = 4'h5,
        OP_TEST_ZERO = 4'h6,
        OP_TEST_NONZERO = 4'h7,
        OP_IF_THEN = 4'h8,
        OP_TBL_BYTE = 4'h9,
        OP_TBL_HALF = 4'ha,
        OP_DEBUG_HALT = 4'hb,
        OP_OTHER = 4'hc
    } bitu_op_t;

    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_TBL = 1'b1
    } bitu_fsm_t;

    // execution-state word, stacked with the status word
    typedef struct packed {
        logic [3:0] base;
        logic [3:0] cur;
        logic [2:0] left;
        logic [2:0] sw;
    } bitu_it_t;
endpackage : bitu_pkg

// ===== include/bitu_it_if.sv
`timescale 1ns/1ps
// Purpose: link between branch control and the if-then state tracker
// Assumes: both ends on clk_sys
// Notes: sw bit 0 is the switch of the next slot, 1 means else
interface bitu_it_if;
    import bitu_pkg::*;
    logic load;
    logic [3:0] load_cond;
    logic [2:0] load_cnt;
    logic [2:0] load_sw;
    logic adv;
    logic clr;
    logic rest;
    bitu_it_t rest_val;
    bitu_it_t st;
    logic active;
    modport ctl (output load, load_cond, load_cnt, load_sw, adv, clr,
        rest, rest_val, input st, active);
    modport trk (input load, load_cond, load_cnt, load_sw, adv, clr,
        rest, rest_val, output st, active);
endinterface : bitu_it_if

// ===== rtl/bitu_it_tracker.sv
`timescale 1ns/1ps
// Purpose: holds the if-then execution state and walks it slot by slot
// Assumes: controller pulses adv once per instruction in the block
// Notes: clear beats restore beats load beats advance
module bitu_it_tracker
    import bitu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    bitu_it_if.trk t
);
    bitu_it_t st_ff;
    bitu_it_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (t.clr)
        begin
            nxt_st = '0;
        end
        else if (t.rest)
        begin
            nxt_st = t.rest_val;
        end
        else if (t.load)
        begin
            nxt_st.base = t.load_cond;
            nxt_st.cur = t.load_cond;
            nxt_st.left = (t.load_cnt > IT_MAX_SLOTS) ? IT_MAX_SLOTS
                : t.load_cnt;
            nxt_st.sw = t.load_sw;
        end
        else if (t.adv && st_ff.left != 3'h0)
        begin
            nxt_st.left = st_ff.left - 3'h1;
            nxt_st.sw = {1'b0, st_ff.sw[2:1]};
            // every-time base never inverts, whatever the switches say
            if (st_ff.sw[0] && st_ff.base != COND_ALWAYS)
                nxt_st.cur = st_ff.base ^ COND_INV_MASK;
            else
                nxt_st.cur = st_ff.base;
            if (st_ff.left == 3'h1)
                nxt_st = '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign t.st = st_ff;
    assign t.active = (st_ff.left != 3'h0);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_last_slot;
        t.adv && !t.clr && !t.rest && !t.load && st_ff.left == 3'h1;
    endsequence
    property p_it_single_ends;
        s_last_slot |=> st_ff.left == 3'h0 && st_ff == '0;
    endproperty
    a_it_single_ends: assert property (p_it_single_ends)
        else $error("block did not clear after its last slot");

    property p_else_inverts;
        (t.adv && !t.clr && !t.rest && !t.load && st_ff.left > 3'h1
            && st_ff.base != COND_ALWAYS)
            |=> st_ff.cur == ($past(st_ff.sw[0])
                ? ($past(st_ff.base) ^ COND_INV_MASK) : $past(st_ff.base));
    endproperty
    a_else_inverts: assert property (p_else_inverts)
        else $error("slot condition does not follow its switch");

    property p_restore;
        t.rest && !t.clr |=> st_ff == $past(t.rest_val);
    endproperty
    a_restore: assert property (p_restore)
        else $error("block state not restored on exception return");
endmodule : bitu_it_tracker

// ===== rtl/bitu_branch_unit.sv
`timescale 1ns/1ps
// Purpose: executes jumps, calls, zero tests, table jumps and if-then
// Assumes: decoder gives op, pc, operands; cond_true judges the
//   condition that applies to the issued instruction
// Notes: table entries come back over a simple read request port
module bitu_branch_unit
    import bitu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic issue_valid,
    input wire bitu_pkg::bitu_op_t issue_op,
    input wire logic [bitu_pkg::XLEN-1:0] issue_pc,
    input wire logic issue_wide,
    input wire logic [bitu_pkg::XLEN-1:0] issue_imm,
    input wire logic [bitu_pkg::XLEN-1:0] issue_opa,
    input wire logic [bitu_pkg::XLEN-1:0] issue_opb,
    input wire logic issue_base_pc,
    input wire logic [3:0] issue_it_cond,
    input wire logic [2:0] issue_it_cnt,
    input wire logic [2:0] issue_it_sw,
    input wire logic cond_true,
    input wire logic tbl_rd_valid,
    input wire logic [15:0] tbl_rd_data,
    input wire logic exc_take,
    input wire logic exc_return,
    input wire bitu_pkg::bitu_it_t exc_state,
    output logic issue_ready,
    output logic retire,
    output logic annul,
    output logic flags_keep,
    output logic br_taken,
    output logic [bitu_pkg::XLEN-1:0] br_target,
    output logic link_we,
    output logic [3:0] link_idx,
    output logic [bitu_pkg::XLEN-1:0] link_wdata,
    output logic fault,
    output logic halt_req,
    output logic tbl_rd_req,
    output logic [bitu_pkg::XLEN-1:0] tbl_rd_addr,
    output logic tbl_half,
    output bitu_pkg::bitu_it_t it_state,
    output bitu_pkg::bitu_it_t saved_state
);
    typedef struct packed {
        bitu_fsm_t fsm;
        logic ready;
        logic retire;
        logic annul;
        logic flags_keep;
        logic br_taken;
        logic [XLEN-1:0] br_target;
        logic link_we;
        logic [XLEN-1:0] link_wdata;
        logic fault;
        logic halt_req;
        logic tbl_rd_req;
        logic [XLEN-1:0] tbl_rd_addr;
        logic tbl_half;
        logic [XLEN-1:0] tbl_from;
        bitu_it_t saved;
    } bitu_state_t;

    bitu_state_t st_ff;
    bitu_state_t nxt_st;
    bitu_it_if itc ();

    logic issue_fire;
    logic in_blk;
    logic slot_pass;
    logic [XLEN-1:0] next_pc;
    logic [XLEN-1:0] near_tgt;
    logic [XLEN-1:0] far_tgt;
    logic [XLEN-1:0] reg_tgt;
    logic [XLEN-1:0] tbl_addr;

    function automatic logic [XLEN-1:0] sext_ofs(
        input logic [XLEN-1:0] v,
        input logic far
    );
        if (far)
            return {{(XLEN-FAR_W){v[FAR_W-1]}}, v[FAR_W-1:0]};
        return {{(XLEN-NEAR_W){v[NEAR_W-1]}}, v[NEAR_W-1:0]};
    endfunction : sext_ofs

    function automatic logic is_branch_op(input bitu_op_t op);
        return op != OP_NONE && op != OP_OTHER;
    endfunction : is_branch_op

    bitu_it_tracker u_it (
        .clk_sys(clk_sys),
        .rst(rst),
        .t(itc.trk)
    );

    // only taken while ready shows; exception entry or return wins
    assign issue_fire = issue_valid && st_ff.ready
        && !exc_take && !exc_return;
    assign in_blk = itc.active;
    assign next_pc = issue_pc + (issue_wide ? WIDE_BYTES : NARROW_BYTES);
    assign near_tgt = issue_pc + sext_ofs(issue_imm, 1'b0);
    assign far_tgt = issue_pc + sext_ofs(issue_imm, 1'b1);
    assign reg_tgt = {issue_opa[XLEN-1:1], 1'b0};
    assign tbl_addr = (issue_base_pc ? next_pc : issue_opa)
        + ((issue_op == OP_TBL_HALF) ? (issue_opb << TBL_SHIFT)
        : issue_opb);
    // outside a block only the conditional jump has a condition
    assign slot_pass = (issue_op == OP_COND_JUMP || in_blk)
        ? cond_true : 1'b1;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.retire = 1'b0;
        nxt_st.annul = 1'b0;
        nxt_st.flags_keep = 1'b0;
        nxt_st.br_taken = 1'b0;
        nxt_st.link_we = 1'b0;
        nxt_st.fault = 1'b0;
        nxt_st.halt_req = 1'b0;
        nxt_st.tbl_rd_req = 1'b0;
        itc.load = 1'b0;
        itc.load_cond = issue_it_cond;
        itc.load_cnt = issue_it_cnt;
        itc.load_sw = issue_it_sw;
        itc.adv = 1'b0;
        itc.clr = 1'b0;
        itc.rest = 1'b0;
        itc.rest_val = exc_state;
        if (exc_take)
        begin
            // snapshot for the stacked status word, then leave the block
            nxt_st.saved = itc.st;
            itc.clr = 1'b1;
            nxt_st.fsm = S_IDLE;
        end
        else if (exc_return)
        begin
            itc.rest = 1'b1;
        end
        else
        begin
            case (st_ff.fsm)
                S_IDLE:
                begin
                    if (issue_fire)
                    begin
                        nxt_st.retire = 1'b1;
                        nxt_st.annul = !slot_pass;
                        nxt_st.flags_keep = is_branch_op(issue_op);
                        itc.adv = in_blk && issue_op != OP_IF_THEN;
                        case (issue_op)
                            OP_JUMP_DIRECT:
                            begin
                                nxt_st.br_taken = slot_pass;
                                nxt_st.br_target = far_tgt;
                            end
                            OP_CALL_DIRECT:
                            begin
                                nxt_st.br_taken = slot_pass;
                                nxt_st.br_target = far_tgt;
                                nxt_st.link_we = slot_pass;
                                nxt_st.link_wdata = next_pc;
                            end
                            OP_COND_JUMP:
                            begin
                                nxt_st.br_taken = slot_pass;
                                nxt_st.br_target = in_blk ? far_tgt
                                    : near_tgt;
                            end
                            OP_JUMP_REG,
                            OP_CALL_REG:
                            begin
                                if (slot_pass && !issue_opa[TGT_MODE_BIT])
                                begin
                                    nxt_st.fault = 1'b1;
                                end
                                else if (slot_pass)
                                begin
                                    nxt_st.br_taken = 1'b1;
                                    nxt_st.br_target = reg_tgt;
                                    // relies on the pc never being the target
                                    nxt_st.link_we =
                                        issue_op == OP_CALL_REG;
                                    nxt_st.link_wdata = next_pc;
                                end
                            end
                            OP_TEST_ZERO,
                            OP_TEST_NONZERO:
                            begin
                                nxt_st.annul = 1'b0;
                                nxt_st.br_taken = (issue_opa == '0)
                                    ^ (issue_op == OP_TEST_NONZERO);
                                nxt_st.br_target = issue_pc + issue_imm;
                            end
                            OP_IF_THEN:
                            begin
                                nxt_st.annul = 1'b0;
                                itc.load = 1'b1;
                            end
                            OP_TBL_BYTE,
                            OP_TBL_HALF:
                            begin
                                if (slot_pass)
                                begin
                                    nxt_st.retire = 1'b0;
                                    nxt_st.fsm = S_TBL;
                                    nxt_st.tbl_rd_req = 1'b1;
                                    nxt_st.tbl_rd_addr = tbl_addr;
                                    nxt_st.tbl_half =
                                        issue_op == OP_TBL_HALF;
                                    nxt_st.tbl_from = next_pc;
                                end
                            end
                            OP_DEBUG_HALT:
                            begin
                                nxt_st.annul = 1'b0;
                                nxt_st.halt_req = 1'b1;
                            end
                            default:
                            begin
                                nxt_st.flags_keep = 1'b0;
                            end
                        endcase
                    end
                end
                S_TBL:
                begin
                    if (tbl_rd_valid)
                    begin
                        nxt_st.fsm = S_IDLE;
                        nxt_st.retire = 1'b1;
                        nxt_st.flags_keep = 1'b1;
                        nxt_st.br_taken = 1'b1;
                        // entries are unsigned, so the jump is forward only
                        nxt_st.br_target = st_ff.tbl_from + (st_ff.tbl_half
                            ? {15'h0, tbl_rd_data, 1'b0}
                            : {23'h0, tbl_rd_data[7:0], 1'b0});
                    end
                end
                default:
                begin
                    nxt_st.fsm = S_IDLE;
                end
            endcase
        end
        nxt_st.ready = nxt_st.fsm == S_IDLE;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign issue_ready = st_ff.ready;
    assign retire = st_ff.retire;
    assign annul = st_ff.annul;
    assign flags_keep = st_ff.flags_keep;
    assign br_taken = st_ff.br_taken;
    assign br_target = st_ff.br_target;
    assign link_we = st_ff.link_we;
    assign link_idx = LINK_REG_IDX;
    assign link_wdata = st_ff.link_wdata;
    assign fault = st_ff.fault;
    assign halt_req = st_ff.halt_req;
    assign tbl_rd_req = st_ff.tbl_rd_req;
    assign tbl_rd_addr = st_ff.tbl_rd_addr;
    assign tbl_half = st_ff.tbl_half;
    assign it_state = itc.st;
    assign saved_state = st_ff.saved;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_call_link;
        issue_fire && issue_op == OP_CALL_DIRECT && slot_pass
            |=> link_we && link_wdata == $past(next_pc) && br_taken;
    endproperty
    a_call_link: assert property (p_call_link)
        else $error("direct call did not write the return address");

    property p_reg_fault;
        issue_fire && (issue_op == OP_JUMP_REG || issue_op == OP_CALL_REG)
            && slot_pass && !issue_opa[TGT_MODE_BIT]
            |=> fault && !br_taken && !link_we;
    endproperty
    a_reg_fault: assert property (p_reg_fault)
        else $error("bad register target did not fault");

    property p_reg_target;
        issue_fire && (issue_op == OP_JUMP_REG || issue_op == OP_CALL_REG)
            && slot_pass && issue_opa[TGT_MODE_BIT]
            |=> br_taken && !fault && br_target[0] == 1'b0
            && br_target[XLEN-1:1] == $past(issue_opa[XLEN-1:1]);
    endproperty
    a_reg_target: assert property (p_reg_target)
        else $error("register target not formed with bit 0 cleared");

    property p_near_range;
        issue_fire && issue_op == OP_COND_JUMP && !in_blk && cond_true
            |=> br_taken && br_target == $past(near_tgt);
    endproperty
    a_near_range: assert property (p_near_range)
        else $error("outside conditional jump used the wrong reach");

    property p_far_range;
        issue_fire && in_blk && cond_true && (issue_op == OP_COND_JUMP
            || issue_op == OP_JUMP_DIRECT)
            |=> br_taken && br_target == $past(far_tgt);
    endproperty
    a_far_range: assert property (p_far_range)
        else $error("block jump used the wrong reach");

    property p_zero_test;
        issue_fire && issue_op == OP_TEST_ZERO
            |=> flags_keep && retire && br_taken == ($past(issue_opa) == '0);
    endproperty
    a_zero_test: assert property (p_zero_test)
        else $error("zero test branched wrongly or touched flags");

    property p_halt_always;
        issue_fire && issue_op == OP_DEBUG_HALT |=> halt_req && !annul;
    endproperty
    a_halt_always: assert property (p_halt_always)
        else $error("debug halt suppressed inside block");

    sequence s_half_issue;
        issue_fire && issue_op == OP_TBL_HALF && slot_pass && issue_base_pc;
    endsequence
    property p_half_addr;
        s_half_issue |=> tbl_rd_req && tbl_half && !issue_ready
            && tbl_rd_addr == $past(next_pc + (issue_opb << TBL_SHIFT));
    endproperty
    a_half_addr: assert property (p_half_addr)
        else $error("half table address not formed from doubled index");

    sequence s_entry_back;
        st_ff.fsm == S_TBL && tbl_rd_valid && !exc_take && !exc_return;
    endsequence
    property p_tbl_jump;
        s_entry_back |=> br_taken && retire && flags_keep
            && br_target >= $past(st_ff.tbl_from);
    endproperty
    a_tbl_jump: assert property (p_tbl_jump)
        else $error("table jump not forward from next instruction");

    property p_it_flags;
        issue_fire && issue_op == OP_IF_THEN
            |=> flags_keep && !br_taken
            && it_state.base == $past(issue_it_cond);
    endproperty
    a_it_flags: assert property (p_it_flags)
        else $error("if-then prefix disturbed flags or lost its condition");
endmodule : bitu_branch_unit

// ===== verif/bitu_table_mem.sv
`timescale 1ns/1ps
// Purpose: table memory answering the unit's entry reads
// Assumes: one read outstanding at a time
// Notes: entry is a function of the address; data scrambles when idle
module bitu_table_mem
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tbl_rd_req,
    input wire logic [31:0] tbl_rd_addr,
    input wire logic [3:0] lat,
    output logic tbl_rd_valid,
    output logic [15:0] tbl_rd_data
);
    logic busy;
    logic [3:0] cnt;
    logic [31:0] a;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            cnt <= 4'h0;
            a <= 32'h0;
            tbl_rd_valid <= 1'b0;
            tbl_rd_data <= 16'h0;
        end
        else
        begin
            tbl_rd_valid <= 1'b0;
            // no hold past the valid cycle
            tbl_rd_data <= ~tbl_rd_data;
            if (tbl_rd_req)
            begin
                busy <= 1'b1;
                cnt <= lat;
                a <= tbl_rd_addr;
            end
            else if (busy && cnt != 4'h0)
                cnt <= cnt - 4'h1;
            else if (busy)
            begin
                busy <= 1'b0;
                tbl_rd_valid <= 1'b1;
                tbl_rd_data <= {~a[7:0], a[7:0]};
            end
        end
    end
endmodule : bitu_table_mem

// ===== verif/bitu_branch_unit_bench.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for the branch unit
// Assumes: table entries come from the table memory model
// Notes: upper entry byte is junk for byte tables on purpose
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module bitu_branch_unit_bench;
    import bitu_pkg::*;
    logic clk_sys;
    logic rst = 1, issue_valid = 0, issue_wide = 0, issue_base_pc = 0;
    logic cond_true = 0, exc_take = 0, exc_return = 0, tbl_rd_valid;
    bitu_op_t issue_op = OP_NONE;
    logic [XLEN-1:0] issue_pc = 0, issue_imm = 0, issue_opa = 0;
    logic [XLEN-1:0] issue_opb = 0, br_target, link_wdata, tbl_rd_addr;
    logic [3:0] issue_it_cond = 0, link_idx, lat = 0;
    logic [2:0] issue_it_cnt = 0, issue_it_sw = 0;
    logic [15:0] tbl_rd_data;
    bitu_it_t exc_state = '0, it_state, saved_state;
    logic issue_ready, retire, annul, flags_keep, br_taken, link_we;
    logic fault, halt_req, tbl_rd_req, tbl_half;
    int err_count = 0, compares = 0;
    bitu_branch_unit i_dut (.clk_sys(clk_sys), .rst(rst),
        .issue_valid(issue_valid), .issue_op(issue_op),
        .issue_pc(issue_pc), .issue_wide(issue_wide),
        .issue_imm(issue_imm), .issue_opa(issue_opa),
        .issue_opb(issue_opb), .issue_base_pc(issue_base_pc),
        .issue_it_cond(issue_it_cond), .issue_it_cnt(issue_it_cnt),
        .issue_it_sw(issue_it_sw), .cond_true(cond_true),
        .tbl_rd_valid(tbl_rd_valid), .tbl_rd_data(tbl_rd_data),
        .exc_take(exc_take), .exc_return(exc_return),
        .exc_state(exc_state), .issue_ready(issue_ready),
        .retire(retire), .annul(annul), .flags_keep(flags_keep),
        .br_taken(br_taken), .br_target(br_target), .link_we(link_we),
        .link_idx(link_idx), .link_wdata(link_wdata), .fault(fault),
        .halt_req(halt_req), .tbl_rd_req(tbl_rd_req),
        .tbl_rd_addr(tbl_rd_addr), .tbl_half(tbl_half),
        .it_state(it_state), .saved_state(saved_state));
    bitu_table_mem i_mem (.clk_sys(clk_sys), .rst(rst),
        .tbl_rd_req(tbl_rd_req), .tbl_rd_addr(tbl_rd_addr), .lat(lat),
        .tbl_rd_valid(tbl_rd_valid), .tbl_rd_data(tbl_rd_data));
    initial
    begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic iss(bitu_op_t op, logic [31:0] pc, imm, opa, logic w, c);
        @(posedge clk_sys);
        issue_valid <= 1'b1;
        issue_op <= op;
        issue_pc <= pc;
        issue_imm <= imm;
        issue_opa <= opa;
        issue_wide <= w;
        cond_true <= c;
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        #1;
    endtask : iss
    task automatic pulse(logic ret);
        @(posedge clk_sys);
        if (ret)
            exc_return <= 1'b1;
        else
            exc_take <= 1'b1;
        @(posedge clk_sys);
        exc_take <= 1'b0;
        exc_return <= 1'b0;
        #1;
    endtask : pulse
    task automatic t_calls;
        iss(OP_CALL_DIRECT, 32'h0800_0000, 32'h0100_0000, 0, 1, 1);
        `CHK("tgt", 32'h0700_0000, br_target)
        `CHK("lnk", 3'b111, {link_we, flags_keep, retire})
        `CHK("lidx", 4'he, link_idx)
        `CHK("lwd", 32'h0800_0004, link_wdata)
        iss(OP_CALL_REG, 32'h600, 0, 32'h4321, 0, 1);
        `CHK("rtgt", 32'h4320, br_target)
        `CHK("rlwd", 32'h602, link_wdata)
        iss(OP_JUMP_REG, 32'h700, 0, 32'h4320, 0, 1);
        `CHK("flt", 2'b10, {fault, br_taken})
    endtask : t_calls
    task automatic t_cond;
        iss(OP_COND_JUMP, 32'h0040_0000, 32'h0010_0000, 0, 1, 1);
        `CHK("near", 32'h0030_0000, br_target)
        iss(OP_COND_JUMP, 32'h0040_0000, 32'h0010_0000, 0, 1, 0);
        `CHK("fail", 3'b101, {annul, br_taken, flags_keep})
        for (int k = 0; k < 4; k++)
        begin
            iss(k[1] ? OP_TEST_NONZERO : OP_TEST_ZERO, 32'h100, 130,
                {31'h0, k[0]}, 0, 0);
            `CHK("tz", {k[0] == k[1], 2'b01}, {br_taken, annul, flags_keep})
            if (br_taken === 1'b1)
                `CHK("tzt", 32'h182, br_target)
        end
    endtask : t_cond
    task automatic t_tbl(bitu_op_t op, logic bp, logic [31:0] b, i, exp);
        @(posedge clk_sys);
        lat <= bp ? 4'h5 : 4'h0;
        issue_base_pc <= bp;
        issue_opb <= i;
        iss(op, 32'h3000, 0, b, 1, 1);
        `CHK("taddr", (bp ? 32'h3004 : b) + (bp ? i << 1 : i), tbl_rd_addr)
        `CHK("thalf", bp, tbl_half)
        `CHK("treq", 2'b10, {tbl_rd_req, issue_ready})
        for (int n = 0; n < 20 && retire !== 1'b1; n++)
            @(posedge clk_sys) #1;
        `CHK("tret", 1'b1, retire)
        `CHK("ttgt", 32'h3004 + (exp << 1), br_target)
    endtask : t_tbl
    task automatic t_block;
        @(posedge clk_sys);
        issue_it_cond <= 4'h3;
        issue_it_cnt <= 3'h3;
        issue_it_sw <= 3'b010;
        iss(OP_IF_THEN, 32'h200, 0, 0, 0, 1);
        `CHK("ld", {4'h3, 4'h3, 3'h3, 3'b010}, it_state)
        pulse(1'b0);
        `CHK("sav", {4'h3, 4'h3, 3'h3, 3'b010}, saved_state)
        `CHK("clr", 3'h0, it_state.left)
        @(posedge clk_sys);
        exc_state <= saved_state;
        pulse(1'b1);
        `CHK("rest", {4'h3, 4'h3, 3'h3, 3'b010}, it_state)
        iss(OP_OTHER, 32'h202, 0, 0, 0, 1);
        `CHK("s2", {4'h3, 3'h2}, {it_state.cur, it_state.left})
        iss(OP_DEBUG_HALT, 32'h204, 0, 0, 0, 0);
        `CHK("halt", 2'b10, {halt_req, annul})
        `CHK("s3", {4'h2, 3'h1}, {it_state.cur, it_state.left})
        iss(OP_COND_JUMP, 32'h206, 32'h0010_0000, 0, 1, 1);
        `CHK("far", 32'h0010_0206, br_target)
        `CHK("end", 11'h0, it_state)
        @(posedge clk_sys);
        issue_it_cond <= 4'he;
        issue_it_cnt <= 3'h2;
        issue_it_sw <= 3'b000;
        iss(OP_IF_THEN, 32'h300, 0, 0, 0, 1);
        iss(OP_OTHER, 32'h302, 0, 0, 0, 1);
        `CHK("aw", {4'he, 3'h1}, {it_state.cur, it_state.left})
        iss(OP_JUMP_DIRECT, 32'h304, 32'h00ff_fffe, 0, 1, 1);
        `CHK("jd", {1'b1, 32'h0100_0302}, {br_taken, br_target})
        `CHK("aend", 11'h0, it_state)
    endtask : t_block
    task report_and_stop;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #200us;
        err_count++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_calls();
        t_cond();
        t_tbl(OP_TBL_BYTE, 0, 32'h2000_0100, 5, 32'h05);
        t_tbl(OP_TBL_HALF, 1, 0, 3, 32'hf50a);
        t_block();
        report_and_stop();
    end
endmodule : bitu_branch_unit_bench
